// *** pg_pkg.sv ***
// Package for the port 1 GPIO block: register offsets, field layout, reset values.
// Assumes a classic Wishbone slave with 32-bit data, registers in the low byte.
package pg_pkg;
    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam logic [3:0] PG_OFF_FSEL = 4'h0;
    localparam logic [3:0] PG_OFF_DIR = 4'h4;
    localparam logic [3:0] PG_OFF_DATA = 4'h8;
    localparam logic [3:0] PG_OFF_PULL = 4'hc;

    // ****************************************
    // Field layout
    // ****************************************
    localparam int PG_FS_EXT_INT3 = 7;
    localparam int PG_FS_EXT_INT2 = 6;
    localparam int PG_FS_EXT_INT1 = 5;
    localparam int PG_FS_EXT_INT0 = 4;
    localparam int PG_FS_TXD = 1;
    localparam int PG_FS_WAVE = 0;
    // Implemented pin bits (no bit 3 pin)
    localparam logic [7:0] PG_PIN_MASK = 8'hf7;
    // Writable function-select bits
    localparam logic [7:0] PG_FS_MASK = 8'hf3;
    // Reserved bits that read as one
    localparam logic [7:0] PG_FS_RSV1 = 8'h0c;
    localparam logic [7:0] PG_DATA_RSV1 = 8'h08;
    localparam logic [7:0] PG_PULL_RSV1 = 8'h08;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] PG_RST_FSEL = 8'h00;
    localparam logic [7:0] PG_RST_DIR = 8'h00;
    localparam logic [7:0] PG_RST_DATA = 8'h00;
    localparam logic [7:0] PG_RST_PULL = 8'h00;
endpackage

// *** pg_port1.sv ***
// Port 1 GPIO with pin function select, behind a classic Wishbone slave.
// Assumes pins, peripheral outputs and bus inputs are synchronous to clk_i.
`timescale 1ns/10ps
`default_nettype none

module pg_port1 (
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // Port 1 pins
    input wire logic [7:0] port1_pin_i,
    output logic [7:0] port1_pin_o,
    output logic [7:0] port1_pin_oe_o,
    output logic [7:0] port1_pullup_o,
    // Port 2 pin 2 transmit routing
    input wire logic port2_pin2_gpio_out_i,
    input wire logic port2_pin2_gpio_oe_i,
    input wire logic serial_txd_i,
    output logic port2_pin2_o,
    output logic port2_pin2_oe_o,
    // Peripheral inputs and outputs
    input wire logic timer_waveform_i,
    output logic [3:0] ext_interrupt_o,
    output logic timer_trigger_input_o
);
    import pg_pkg::*;

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [7:0] fsel;
        logic [7:0] dir;
        logic [7:0] data;
        logic [7:0] pull;
        logic ack;
        logic err;
        logic [7:0] rdat;
    } pg_state_s;

    pg_state_s st_q;
    pg_state_s st_d;

    // Byte lane 0 write strobe for one address
    function automatic logic pg_wr(input logic [3:0] adr, input logic [3:0] off,
                                   input logic req, input logic we, input logic sel0);
        pg_wr = req && we && sel0 && (adr == off);
    endfunction

    logic req;
    logic mapped;
    logic [7:0] gpio_oe;
    logic [7:0] data_rd;

    // New request only when no answer is standing, so each access acks once
    assign req = wb_cyc_i && wb_stb_i && !st_q.ack && !st_q.err;
    assign mapped = (wb_adr_i == PG_OFF_FSEL) || (wb_adr_i == PG_OFF_DIR) ||
                    (wb_adr_i == PG_OFF_DATA) || (wb_adr_i == PG_OFF_PULL);

    // Direction only counts where the pin is not taken by a peripheral
    assign gpio_oe = st_q.dir & PG_PIN_MASK & ~{st_q.fsel[7:4], 4'h0};

    // Latch where output, pin level where input
    assign data_rd = ((st_q.data & st_q.dir) | (port1_pin_i & ~st_q.dir)) & PG_PIN_MASK
                     | PG_DATA_RSV1;

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        st_d = st_q;
        st_d.ack = req && mapped;
        st_d.err = req && !mapped;
        // Reserved positions masked off so they never store
        if (pg_wr(wb_adr_i, PG_OFF_FSEL, req, wb_we_i, wb_sel_i[0])) begin
            st_d.fsel = wb_dat_i[7:0] & PG_FS_MASK;
        end
        if (pg_wr(wb_adr_i, PG_OFF_DIR, req, wb_we_i, wb_sel_i[0])) begin
            st_d.dir = wb_dat_i[7:0] & PG_PIN_MASK;
        end
        if (pg_wr(wb_adr_i, PG_OFF_DATA, req, wb_we_i, wb_sel_i[0])) begin
            st_d.data = wb_dat_i[7:0] & PG_PIN_MASK;
        end
        if (pg_wr(wb_adr_i, PG_OFF_PULL, req, wb_we_i, wb_sel_i[0])) begin
            st_d.pull = wb_dat_i[7:0] & PG_PIN_MASK;
        end
        // Read data captured at request; direction is write-only, reads zero
        st_d.rdat = 8'h00;
        if (req && !wb_we_i) begin
            unique case (wb_adr_i)
                PG_OFF_FSEL: st_d.rdat = st_q.fsel | PG_FS_RSV1;
                PG_OFF_DATA: st_d.rdat = data_rd;
                PG_OFF_PULL: st_d.rdat = st_q.pull | PG_PULL_RSV1;
                default: st_d.rdat = 8'h00;
            endcase
        end
        if (rst_i) begin
            st_d.fsel = PG_RST_FSEL;
            st_d.dir = PG_RST_DIR;
            st_d.data = PG_RST_DATA;
            st_d.pull = PG_RST_PULL;
            st_d.ack = 1'b0;
            st_d.err = 1'b0;
            st_d.rdat = 8'h00;
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        st_q <= st_d;
    end

    // ****************************************
    // Bus outputs
    // ****************************************
    assign wb_ack_o = st_q.ack;
    assign wb_err_o = st_q.err;
    assign wb_dat_o = {24'h000000, st_q.rdat};

    // ****************************************
    // Pin routing
    // ****************************************
    // Pin 0 either timer waveform or latch; other pins from latch
    always_comb begin
        port1_pin_o = st_q.data & PG_PIN_MASK;
        port1_pin_oe_o = gpio_oe;
        if (st_q.fsel[PG_FS_WAVE]) begin
            port1_pin_o[0] = timer_waveform_i;
            port1_pin_oe_o[0] = 1'b1;
        end
    end

    // Pull-ups only on pins whose direction bit is clear, even where the pin is taken by a peripheral
    assign port1_pullup_o = st_q.pull & ~st_q.dir & PG_PIN_MASK;

    // Interrupt inputs gated low when not selected to avoid spurious edges
    assign ext_interrupt_o = {port1_pin_i[7] & st_q.fsel[PG_FS_EXT_INT3],
                              port1_pin_i[6] & st_q.fsel[PG_FS_EXT_INT2],
                              port1_pin_i[5] & st_q.fsel[PG_FS_EXT_INT1],
                              port1_pin_i[4] & st_q.fsel[PG_FS_EXT_INT0]};
    assign timer_trigger_input_o = port1_pin_i[7] & st_q.fsel[PG_FS_EXT_INT3];

    // Port 2 pin 2: transmit output overrides its own GPIO control
    assign port2_pin2_o = st_q.fsel[PG_FS_TXD] ? serial_txd_i : port2_pin2_gpio_out_i;
    assign port2_pin2_oe_o = st_q.fsel[PG_FS_TXD] | port2_pin2_gpio_oe_i;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    fsel_rsv_a: assert property (st_q.fsel[3:2] == 2'b00 && st_q.dir[3] == 1'b0)
        else $error("reserved bit stored");
    pin7_int_a: assert property (st_q.fsel[7] |-> !port1_pin_oe_o[7] &&
        ext_interrupt_o[3] == port1_pin_i[7] && timer_trigger_input_o == port1_pin_i[7])
        else $error("pin 7 not routed to interrupt");
    pin6_int_a: assert property (st_q.fsel[6] |-> !port1_pin_oe_o[6] &&
        ext_interrupt_o[2] == port1_pin_i[6]) else $error("pin 6 not routed");
    pin5_int_a: assert property (st_q.fsel[5] |-> !port1_pin_oe_o[5] &&
        ext_interrupt_o[1] == port1_pin_i[5]) else $error("pin 5 not routed");
    pin4_int_a: assert property (st_q.fsel[4] |-> !port1_pin_oe_o[4] &&
        ext_interrupt_o[0] == port1_pin_i[4]) else $error("pin 4 not routed");
    fsel_read_a: assert property (req && !wb_we_i && wb_adr_i == PG_OFF_FSEL |=>
        wb_ack_o && wb_dat_o[3:2] == 2'b11) else $error("select read wrong");
    txd_route_a: assert property (st_q.fsel[1] |-> port2_pin2_oe_o &&
        port2_pin2_o == serial_txd_i) else $error("transmit not routed");
    timer_waveform_output_select_route_a: assert property (st_q.fsel[0] |-> port1_pin_oe_o[0] &&
        port1_pin_o[0] == timer_waveform_i) else $error("waveform not routed");
    dir_out_a: assert property (!st_q.fsel[5] |-> port1_pin_oe_o[5] == st_q.dir[5])
        else $error("direction not applied");
    data_write_a: assert property (pg_wr(wb_adr_i, PG_OFF_DATA, req, wb_we_i, wb_sel_i[0])
        ##1 !rst_i |-> port1_pin_o[2] == $past(wb_dat_i[2]))
        else $error("data write not driven");
    data_read_a: assert property (req && !wb_we_i && wb_adr_i == PG_OFF_DATA |=>
        wb_dat_o[7:0] == ($past(data_rd))) else $error("data read wrong");
    rsv_read_a: assert property (req && !wb_we_i && wb_adr_i == PG_OFF_PULL |=>
        wb_dat_o[3] == 1'b1) else $error("pull-up bit 3 not one");
    pull_gate_a: assert property (st_q.dir[1] |-> !port1_pullup_o[1])
        else $error("pull-up on output pin");
    ack_once_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");

    cov_irq_c: cover property (st_q.fsel[7] && ext_interrupt_o[3]);
    cov_read_c: cover property (wb_ack_o && st_q.dir != 8'h00);
    cov_txd_c: cover property (st_q.fsel[1] && port2_pin2_o);
    cov_err_c: cover property (wb_err_o);

endmodule // pg_port1

`default_nettype wire

// *** pg_pins.sv ***
// Package pin model standing outside the port 1 block.
// Assumes all levels settle within one clk_i cycle; no analog strength.
`timescale 1ns/10ps
`default_nettype none

module pg_pins (
    input wire logic clk_i,
    input wire logic [7:0] drv_i,
    input wire logic [7:0] drv_oe_i,
    input wire logic [7:0] pullup_i,
    input wire logic [7:0] ext_val_i,
    input wire logic [7:0] ext_en_i,
    output logic [7:0] level_o
);
    // Changing pattern so an undriven pin never reads as a steady value
    logic [7:0] float_q = 8'h55;
    always_ff @(posedge clk_i) begin
        float_q <= ~float_q;
    end
    // Block drive wins, then outside drive, then pull-up, else floating
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            level_o[i] = drv_oe_i[i] ? drv_i[i] : ext_en_i[i] ? ext_val_i[i] :
                         pullup_i[i] ? 1'b1 : float_q[i];
        end
    end
endmodule // pg_pins

`default_nettype wire

// *** test_port1_gpio_with_pin_function_select.sv ***
// Self-checking bench for the port 1 block with a package pin model.
// Assumes a one-cycle registered Wishbone answer from the block.
`timescale 1ns/10ps
`default_nettype none
`define PG_CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
    $display("unexpected %s expected %h seen %h", nm, e, g); end end

module test_port1_gpio_with_pin_function_select;
    import pg_pkg::*;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o;
    logic [3:0] wb_adr_i, ext_int;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [7:0] pin_o, pin_oe, pull, ext_val, ext_en, lvl;
    logic p2_o, p2_oe, txd, tmw, trig, er;
    int errors = 0;
    int checks = 0;

    pg_pins pin_u (.clk_i(clk_i), .drv_i(pin_o), .drv_oe_i(pin_oe), .pullup_i(pull),
        .ext_val_i(ext_val), .ext_en_i(ext_en), .level_o(lvl));
    pg_port1 dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'h1), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .port1_pin_i(lvl),
        .port1_pin_o(pin_o), .port1_pin_oe_o(pin_oe), .port1_pullup_o(pull),
        .port2_pin2_gpio_out_i(1'b0), .port2_pin2_gpio_oe_i(1'b0), .serial_txd_i(txd),
        .port2_pin2_o(p2_o), .port2_pin2_oe_o(p2_oe), .timer_waveform_i(tmw),
        .ext_interrupt_o(ext_int), .timer_trigger_input_o(trig));

    // ****************************************
    // Bus cycles and closing
    // ****************************************
    task automatic test_done();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Classic single cycle; bounded wait so a dead slave cannot hang
    task automatic bus(input logic we, input logic [3:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= we;
        wb_adr_i <= a; wb_dat_i <= {24'h0, d};
        // Answer looked at mid-cycle where it is settled; it stands to the next edge
        do begin
            @(negedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1) begin
            errors++;
            $display("unexpected bus answer expected 1 seen 0");
        end
        rd = wb_dat_o;
        er = wb_err_o;
        @(posedge clk_i);
        wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0;
    endtask
    task automatic rchk(input logic [3:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        `PG_CHK("read data", {24'h0, e}, rd)
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        rchk(PG_OFF_FSEL, 8'h0c);
        rchk(PG_OFF_DIR, 8'h00);
        rchk(PG_OFF_PULL, 8'h08);
        `PG_CHK("oe", 8'h00, pin_oe)
        `PG_CHK("pullup", 8'h00, pull)
    endtask
    task automatic t_gpio();
        bus(1'b1, PG_OFF_DIR, 8'hff);
        bus(1'b1, PG_OFF_DATA, 8'ha5);
        @(negedge clk_i);
        `PG_CHK("oe", 8'hf7, pin_oe)
        `PG_CHK("pin out", 8'ha5, pin_o)
        rchk(PG_OFF_DATA, 8'had);
        rchk(PG_OFF_DIR, 8'h00);
    endtask
    task automatic t_input();
        bus(1'b1, PG_OFF_DIR, 8'h00);
        ext_en <= 8'hff; ext_val <= 8'h52;
        rchk(PG_OFF_DATA, 8'h5a);
        ext_en <= 8'h00;
        bus(1'b1, PG_OFF_PULL, 8'hff);
        @(negedge clk_i);
        `PG_CHK("pullup", 8'hf7, pull)
        rchk(PG_OFF_DATA, 8'hff);
        bus(1'b1, PG_OFF_DIR, 8'hff);
        @(negedge clk_i);
        `PG_CHK("pullup", 8'h00, pull)
    endtask
    // Every select bit at once, then all released again
    task automatic t_select();
        @(posedge clk_i);
        ext_en <= 8'hf0; ext_val <= 8'h90; tmw <= 1'b1; txd <= 1'b1;
        bus(1'b1, PG_OFF_FSEL, 8'hff);
        @(negedge clk_i);
        `PG_CHK("interrupts", 4'h9, ext_int)
        `PG_CHK("trigger", 1'b1, trig)
        `PG_CHK("oe", 8'h07, pin_oe)
        `PG_CHK("pin0", 1'b1, pin_o[0])
        `PG_CHK("port2 pin", 2'b11, {p2_o, p2_oe})
        rchk(PG_OFF_FSEL, 8'hff);
        bus(1'b1, PG_OFF_FSEL, 8'h00);
        @(negedge clk_i);
        `PG_CHK("interrupts", 4'h0, ext_int)
        `PG_CHK("oe", 8'hf7, pin_oe)
        `PG_CHK("port2 pin", 2'b00, {p2_o, p2_oe})
        rchk(PG_OFF_FSEL, 8'h0c);
    endtask
    task automatic t_unmapped();
        bus(1'b0, 4'h2, 8'h00);
        `PG_CHK("error", 1'b1, er)
    endtask

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    // Watchdog well beyond the few dozen cycles the run needs
    initial begin
        repeat (3000) @(posedge clk_i);
        errors++;
        test_done();
    end
    initial begin
        rst_i = 1'b1; wb_cyc_i = 1'b0; wb_stb_i = 1'b0; wb_we_i = 1'b0;
        wb_adr_i = 4'h0; wb_dat_i = 32'h0; ext_val = 8'h00; ext_en = 8'h00;
        txd = 1'b0; tmw = 1'b0;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_gpio();
        t_input();
        t_select();
        t_unmapped();
        test_done();
    end
endmodule // test_port1_gpio_with_pin_function_select

`default_nettype wire
